// [design/asid_dev.sv]
// Decoder end: slot/index decode onto terminals, cycle data and images
`timescale 1ns/10ps
module asid_dev
  import asid_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  asid_if.dev lnk,
  input wire logic [6:0] term_cnt,
  output logic treg_req_ff,
  output logic treg_we_ff,
  output logic [7:0] treg_slot_ff,
  output logic [7:0] treg_num_ff,
  output logic [15:0] treg_wdat_ff,
  input wire logic treg_ack,
  input wire logic [15:0] treg_rdat,
  input wire logic [63:0] cyc_times,
  output logic cyc_meas_ff,
  output logic cyc_load_ff,
  output logic [63:0] cyc_val_ff,
  output logic wprot_ff,
  output logic factory_ff,
  output logic tbus_rst_ff,
  input wire logic [10:0] img_addr,
  output logic [7:0] img_rdat_ff
);
  // ----------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_WCOL = 3'b001, S_CHK = 3'b010, S_TREG = 3'b011,
    S_RD = 3'b100, S_WR = 3'b101, S_RSP = 3'b110
  } asid_st_e;
  typedef enum logic [2:0] {
    K_TREG = 3'b000, K_IMG_RD = 3'b001, K_CYC_RD = 3'b010, K_FUNC = 3'b011,
    K_MEAS = 3'b100, K_CYC_WR = 3'b101, K_IMG_WR = 3'b110, K_BIT = 3'b111
  } asid_kind_e;

  asid_st_e st_ff;
  asid_kind_e kind_ff, kind;
  logic wr_ff, conn_ff, err_ff, bad;
  logic [7:0] slot_ff, idx_ff;
  logic [5:0] len_ff, cnt_ff;
  logic [1:0] area_ff, area;
  logic [9:0] base_ff, base;
  logic [2:0] bit_ff;
  logic [15:0] word_ff, ofs;
  logic [16:0] lim;
  logic [7:0] wbuf [0:47];
  logic [7:0] img_mem [0:2047];
  logic [9:0] addr;

  assign ofs = {wbuf[0], wbuf[1]};
  assign addr = base_ff + 10'(cnt_ff);

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  // Classify request and flag any range fault
  always_comb begin
    bad = 1'b0;
    kind = K_FUNC;
    area = 2'b00;
    base = 10'h000;
    lim = 17'h0_0000;
    if (!asid_len_ok(wr_ff, slot_ff, idx_ff, len_ff)) begin
      bad = 1'b1;
    end else if (slot_ff != SLOT_CTRL && slot_ff <= SLOT_TERM_MAX) begin
      kind = K_TREG;
      base = {2'b00, idx_ff};
      lim = 17'(idx_ff) + 17'(len_ff[5:1]);
      bad = slot_ff > {1'b0, term_cnt} || lim > 17'h0_0100;
      bad = bad || (wr_ff && wprot_ff);
    end else if (slot_ff >= SLOT_OUT && slot_ff <= SLOT_FLAG) begin
      kind = K_IMG_RD;
      area = 2'(slot_ff - SLOT_OUT);
      base = {1'b0, idx_ff, 1'b0};
      lim = 17'({idx_ff, 1'b0}) + 17'(len_ff);
      bad = wr_ff || lim > IMG_BYTES;
    end else if (slot_ff != SLOT_CTRL) begin
      bad = 1'b1;
    end else if (!wr_ff) begin
      if (idx_ff >= IDX_DESIG_LO && idx_ff <= IDX_DESIG_HI) begin
        kind = K_TREG;
        base = 10'((idx_ff - IDX_DESIG_LO) * DESIG_PER_IDX);
        lim = 17'(base) + 17'(len_ff[5:1]);
        bad = lim > 17'(DESIG_LAST) + 17'h0_0001;
      end else if (idx_ff == IDX_CYC) begin
        kind = K_CYC_RD;
        bad = len_ff != CYC_LEN;
      end else if (idx_ff[7:6] == 2'b10 && idx_ff[5:4] != 2'b11 && idx_ff[3:0] <= WIN_LAST)
      begin
        kind = K_IMG_RD;
        area = idx_ff[5:4];
        base = 10'(idx_ff[3:0] * WIN_BYTES);
        lim = 17'(base) + 17'(len_ff);
        bad = lim > IMG_BYTES;
      end else begin
        bad = 1'b1;
      end
    end else if (wprot_ff && idx_ff != IDX_FUNC) begin
      bad = 1'b1;
    end else if (idx_ff == IDX_FUNC) begin
      kind = K_FUNC;
      bad = wbuf[0] > FN_TBRST;
    end else if (idx_ff == IDX_MEAS) begin
      kind = K_MEAS;
      bad = len_ff != MEAS_LEN;
    end else if (idx_ff == IDX_CYC) begin
      kind = K_CYC_WR;
      bad = len_ff != CYC_LEN;
    end else if (idx_ff >= IDX_WBYTE && idx_ff < IDX_WBIT) begin
      kind = K_IMG_WR;
      area = idx_ff[1:0];
      base = ofs[9:0];
      lim = 17'(ofs) + 17'(len_ff) - 17'(OFS_LEN) + 17'h0_0001;
      bad = lim > IMG_BYTES;
    end else if (idx_ff >= IDX_WBIT && idx_ff <= IDX_WBIT_LAST) begin
      kind = K_BIT;
      area = 2'(idx_ff - IDX_WBIT);
      base = {1'b0, ofs[11:3]};
      bad = ofs >= BIT_LIMIT || wbuf[2] > 8'h01;
    end else begin
      bad = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Take request, gather write bytes, dispatch, stream answer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_ff <= S_IDLE;
      lnk.req_ready <= 1'b0;
      lnk.wb_ready <= 1'b0;
      lnk.rd_valid <= 1'b0;
      lnk.rd_data <= 8'h00;
      lnk.rsp_valid <= 1'b0;
      lnk.rsp_err <= 1'b0;
      lnk.rsp_conn <= 1'b0;
      wr_ff <= 1'b0;
      conn_ff <= 1'b0;
      err_ff <= 1'b0;
      slot_ff <= 8'h00;
      idx_ff <= 8'h00;
      len_ff <= 6'h00;
      cnt_ff <= 6'h00;
      kind_ff <= K_FUNC;
      area_ff <= 2'b00;
      base_ff <= 10'h000;
      bit_ff <= 3'h0;
      word_ff <= 16'h0000;
    end else begin
      lnk.rd_valid <= 1'b0;
      lnk.rsp_valid <= 1'b0;
      case (st_ff)
        S_IDLE: begin
          lnk.req_ready <= 1'b1;
          cnt_ff <= 6'h00;
          if (lnk.req_valid && lnk.req_ready) begin
            lnk.req_ready <= 1'b0;
            wr_ff <= lnk.req_write;
            conn_ff <= lnk.req_conn;
            slot_ff <= lnk.req_slot;
            idx_ff <= lnk.req_index;
            len_ff <= lnk.req_len;
            lnk.wb_ready <= lnk.req_write && lnk.req_len != 6'h00;
            st_ff <= lnk.req_write && lnk.req_len != 6'h00 ? S_WCOL : S_CHK;
          end
        end
        S_WCOL: begin
          if (lnk.wb_valid && lnk.wb_ready) begin
            wbuf[cnt_ff] <= lnk.wb_data;
            cnt_ff <= cnt_ff + 6'h01;
            if (cnt_ff + 6'h01 >= len_ff || cnt_ff + 6'h01 >= DATA_MAX) begin
              lnk.wb_ready <= 1'b0;
              st_ff <= S_CHK;
            end
          end
        end
        S_CHK: begin
          kind_ff <= kind;
          area_ff <= area;
          base_ff <= base;
          bit_ff <= ofs[2:0];
          cnt_ff <= 6'h00;
          err_ff <= bad;
          if (bad)
            st_ff <= S_RSP;
          else if (kind == K_TREG)
            st_ff <= S_TREG;
          else if (kind == K_IMG_RD || kind == K_CYC_RD)
            st_ff <= S_RD;
          else if (kind == K_IMG_WR || kind == K_BIT)
            st_ff <= S_WR;
          else
            st_ff <= S_RSP;
        end
        S_TREG: begin
          if (treg_ack) begin
            word_ff <= treg_rdat;
            if (wr_ff) begin
              cnt_ff <= cnt_ff + 6'h02;
              st_ff <= cnt_ff + 6'h02 >= len_ff ? S_RSP : S_TREG;
            end else begin
              st_ff <= S_RD;
            end
          end
        end
        S_RD: begin
          lnk.rd_valid <= 1'b1;
          cnt_ff <= cnt_ff + 6'h01;
          if (kind_ff == K_IMG_RD)
            lnk.rd_data <= img_mem[{area_ff, addr[8:0]}];
          else if (kind_ff == K_CYC_RD)
            lnk.rd_data <= cyc_times[{~cnt_ff[2:0], 3'b000} +: 8];
          else
            lnk.rd_data <= cnt_ff[0] ? word_ff[7:0] : word_ff[15:8];
          if (cnt_ff + 6'h01 >= len_ff)
            st_ff <= S_RSP;
          else if (kind_ff == K_TREG && cnt_ff[0])
            st_ff <= S_TREG;
        end
        S_WR: begin
          cnt_ff <= cnt_ff + 6'h01;
          if (kind_ff == K_BIT || cnt_ff + 6'h01 + OFS_LEN - 6'h01 >= len_ff)
            st_ff <= S_RSP;
        end
        S_RSP: begin
          lnk.rsp_valid <= 1'b1;
          lnk.rsp_err <= err_ff;
          lnk.rsp_conn <= conn_ff;
          st_ff <= S_IDLE;
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end

  // Terminal register and designation word requests
  always_ff @(posedge clk) begin
    if (!rstn) begin
      treg_req_ff <= 1'b0;
      treg_we_ff <= 1'b0;
      treg_slot_ff <= 8'h00;
      treg_num_ff <= 8'h00;
      treg_wdat_ff <= 16'h0000;
    end else begin
      treg_req_ff <= 1'b0;
      if ((st_ff == S_CHK && !bad && kind == K_TREG) ||
          (st_ff == S_TREG && treg_ack && wr_ff && cnt_ff + 6'h02 < len_ff) ||
          (st_ff == S_RD && kind_ff == K_TREG && cnt_ff[0] && cnt_ff + 6'h01 < len_ff))
      begin
        treg_req_ff <= 1'b1;
        treg_we_ff <= wr_ff;
        treg_slot_ff <= slot_ff;
      end
      if (st_ff == S_CHK) begin
        treg_num_ff <= base[7:0];
        treg_wdat_ff <= {wbuf[0], wbuf[1]};
      end else if (st_ff == S_TREG && treg_ack) begin
        treg_num_ff <= treg_num_ff + 8'h01;
        treg_wdat_ff <= {wbuf[cnt_ff + 6'h02], wbuf[cnt_ff + 6'h03]};
      end
    end
  end

  // Controller functions, protection and cycle-time control
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wprot_ff <= WPROT_RST;
      factory_ff <= 1'b0;
      tbus_rst_ff <= 1'b0;
      cyc_meas_ff <= 1'b0;
      cyc_load_ff <= 1'b0;
      cyc_val_ff <= 64'h0000_0000_0000_0000;
    end else begin
      factory_ff <= 1'b0;
      tbus_rst_ff <= 1'b0;
      cyc_load_ff <= 1'b0;
      if (st_ff == S_CHK && !bad) begin
        if (kind == K_FUNC) begin
          if (wbuf[0] == FN_PROT)
            wprot_ff <= !(len_ff == FUNC_MAX && wbuf[1] == KEY_LO && wbuf[2] == KEY_HI);
          factory_ff <= wbuf[0] == FN_FACT;
          tbus_rst_ff <= wbuf[0] == FN_TBRST;
        end
        if (kind == K_MEAS)
          cyc_meas_ff <= ofs != 16'h0000;
        if (kind == K_CYC_WR) begin
          cyc_load_ff <= 1'b1;
          cyc_val_ff <= {wbuf[0], wbuf[1], wbuf[2], wbuf[3],
                         wbuf[4], wbuf[5], wbuf[6], wbuf[7]};
        end
      end
    end
  end

  // Image memory: byte and bit writes from the link
  always_ff @(posedge clk) begin
    if (st_ff == S_WR) begin
      if (kind_ff == K_BIT)
        img_mem[{area_ff, base_ff[8:0]}][bit_ff] <= wbuf[2][0];
      else
        img_mem[{area_ff, addr[8:0]}] <= wbuf[cnt_ff + 6'h02];
    end
  end

  // User-side image readback
  always_ff @(posedge clk) begin
    if (!rstn)
      img_rdat_ff <= 8'h00;
    else
      img_rdat_ff <= img_mem[img_addr];
  end
endmodule

// [design/asid_pkg.sv]
// Constants and shared checks of the acyclic slot/index decoder
package asid_pkg;
  // ----------------------------------------------------------------
  // Sizes and codes
  // ----------------------------------------------------------------
  localparam int PDU_MAX = 52;
  localparam logic [5:0] DATA_MAX = 6'h30;
  localparam logic [7:0] SLOT_CTRL = 8'h00;
  localparam logic [7:0] SLOT_TERM_MAX = 8'h40;
  localparam logic [7:0] SLOT_OUT = 8'hFB;
  localparam logic [7:0] SLOT_FLAG = 8'hFD;
  localparam logic [7:0] IDX_DESIG_LO = 8'h01;
  localparam logic [7:0] IDX_DESIG_HI = 8'h03;
  localparam logic [7:0] DESIG_PER_IDX = 8'h18;
  localparam logic [7:0] DESIG_LAST = 8'h40;
  localparam logic [7:0] IDX_FUNC = 8'h10;
  localparam logic [7:0] IDX_MEAS = 8'h20;
  localparam logic [7:0] IDX_CYC = 8'h21;
  localparam logic [3:0] WIN_LAST = 4'hA;
  localparam logic [9:0] WIN_BYTES = 10'h030;
  localparam logic [16:0] IMG_BYTES = 17'h0_0200;
  localparam logic [7:0] IDX_WBYTE = 8'hE0;
  localparam logic [7:0] IDX_WBIT = 8'hE3;
  localparam logic [7:0] IDX_WBIT_LAST = 8'hE5;
  localparam logic [15:0] BIT_LIMIT = 16'h1000;
  localparam logic [7:0] FN_PROT = 8'h00;
  localparam logic [7:0] FN_FACT = 8'h01;
  localparam logic [7:0] FN_TBRST = 8'h02;
  localparam logic [7:0] KEY_LO = 8'hFE;
  localparam logic [7:0] KEY_HI = 8'hAF;
  localparam logic [5:0] FUNC_MAX = 6'h03;
  localparam logic [5:0] MEAS_LEN = 6'h02;
  localparam logic [5:0] CYC_LEN = 6'h08;
  localparam logic [5:0] OFS_LEN = 6'h03;
  localparam logic [0:0] WPROT_RST = 1'h0;

  // Length test the master end applies before a request goes on the link and the decoder end applies after taking it
  function automatic logic asid_len_ok(input logic wr, input logic [7:0] slot,
                                       input logic [7:0] idx, input logic [5:0] len);
    logic ok;
    ok = (len != 6'h00) && (len <= DATA_MAX);
    if (slot != SLOT_CTRL && slot <= SLOT_TERM_MAX)
      ok = ok && !len[0];
    else if (slot == SLOT_CTRL && wr) begin
      if (idx == IDX_FUNC)
        ok = ok && len <= FUNC_MAX;
      else if (idx >= IDX_WBIT && idx <= IDX_WBIT_LAST)
        ok = ok && len == OFS_LEN;
      else if (idx >= IDX_WBYTE && idx < IDX_WBIT)
        ok = ok && len >= OFS_LEN;
    end
    return ok;
  endfunction
endpackage

// [design/asid_if.sv]
// Link between the fieldbus master end and the decoder end
`timescale 1ns/10ps
interface asid_if;
  logic req_valid;
  logic req_ready;
  logic req_write;
  logic req_conn;
  logic [7:0] req_slot;
  logic [7:0] req_index;
  logic [5:0] req_len;
  logic wb_valid;
  logic wb_ready;
  logic [7:0] wb_data;
  logic rd_valid;
  logic [7:0] rd_data;
  logic rsp_valid;
  logic rsp_err;
  logic rsp_conn;

  modport dev (input req_valid, req_write, req_conn, req_slot, req_index, req_len,
               wb_valid, wb_data, output req_ready, wb_ready, rd_valid, rd_data,
               rsp_valid, rsp_err, rsp_conn);
  modport mst (output req_valid, req_write, req_conn, req_slot, req_index, req_len,
               wb_valid, wb_data, input req_ready, wb_ready, rd_valid, rd_data,
               rsp_valid, rsp_err, rsp_conn);
endinterface

// [design/asid_mst.sv]
// Master end: issues acyclic read and write requests over the link
`timescale 1ns/10ps
module asid_mst
  import asid_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  asid_if.mst lnk,
  input wire logic cmd_valid,
  output logic cmd_ready_ff,
  input wire logic cmd_write,
  input wire logic cmd_conn,
  input wire logic [7:0] cmd_slot,
  input wire logic [7:0] cmd_index,
  input wire logic [5:0] cmd_len,
  input wire logic ub_we,
  input wire logic [5:0] ub_addr,
  input wire logic [7:0] ub_data,
  output logic usr_rd_valid_ff,
  output logic [7:0] usr_rd_data_ff,
  output logic done_ff,
  output logic done_err_ff,
  output logic done_local_ff
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    M_IDLE = 3'b000, M_REQ = 3'b001, M_WDAT = 3'b010, M_WAIT = 3'b011
  } asid_mst_e;

  asid_mst_e st_ff;
  logic [5:0] cnt_ff;
  logic [7:0] buf_mem [0:47];

  // User loads outgoing data bytes
  always_ff @(posedge clk) begin
    if (ub_we && ub_addr < DATA_MAX)
      buf_mem[ub_addr] <= ub_data;
  end

  // Request sequencer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_ff <= M_IDLE;
      cnt_ff <= 6'h00;
      cmd_ready_ff <= 1'b0;
      done_ff <= 1'b0;
      done_err_ff <= 1'b0;
      done_local_ff <= 1'b0;
      usr_rd_valid_ff <= 1'b0;
      usr_rd_data_ff <= 8'h00;
      lnk.req_valid <= 1'b0;
      lnk.req_write <= 1'b0;
      lnk.req_conn <= 1'b0;
      lnk.req_slot <= 8'h00;
      lnk.req_index <= 8'h00;
      lnk.req_len <= 6'h00;
      lnk.wb_valid <= 1'b0;
      lnk.wb_data <= 8'h00;
    end else begin
      done_ff <= 1'b0;
      usr_rd_valid_ff <= lnk.rd_valid && st_ff == M_WAIT;
      usr_rd_data_ff <= lnk.rd_data;
      case (st_ff)
        M_IDLE: begin
          cmd_ready_ff <= 1'b1;
          cnt_ff <= 6'h00;
          if (cmd_valid && cmd_ready_ff) begin
            cmd_ready_ff <= 1'b0;
            if (!asid_len_ok(cmd_write, cmd_slot, cmd_index, cmd_len)) begin
              done_ff <= 1'b1;
              done_err_ff <= 1'b1;
              done_local_ff <= 1'b1;
            end else begin
              lnk.req_valid <= 1'b1;
              lnk.req_write <= cmd_write;
              lnk.req_conn <= cmd_conn;
              lnk.req_slot <= cmd_slot;
              lnk.req_index <= cmd_index;
              lnk.req_len <= cmd_len;
              st_ff <= M_REQ;
            end
          end
        end
        M_REQ: begin
          if (lnk.req_ready) begin
            lnk.req_valid <= 1'b0;
            lnk.wb_valid <= lnk.req_write;
            lnk.wb_data <= buf_mem[0];
            st_ff <= lnk.req_write ? M_WDAT : M_WAIT;
          end
        end
        M_WDAT: begin
          if (lnk.wb_ready) begin
            cnt_ff <= cnt_ff + 6'h01;
            lnk.wb_data <= buf_mem[cnt_ff + 6'h01];
            if (cnt_ff + 6'h01 >= lnk.req_len) begin
              lnk.wb_valid <= 1'b0;
              st_ff <= M_WAIT;
            end
          end
        end
        M_WAIT: begin
          if (lnk.rsp_valid) begin
            done_ff <= 1'b1;
            done_err_ff <= lnk.rsp_err;
            done_local_ff <= 1'b0;
            st_ff <= M_IDLE;
          end
        end
        default: st_ff <= M_IDLE;
      endcase
    end
  end
endmodule

// [tb/asid_properties.sv]
// Link checker between the master end and the decoder end
`timescale 1ns/10ps
module asid_properties (
  input wire logic clk,
  input wire logic rstn,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_write,
  input wire logic req_conn,
  input wire logic [7:0] req_slot,
  input wire logic [5:0] req_len,
  input wire logic wb_valid,
  input wire logic wb_ready,
  input wire logic [7:0] wb_data,
  input wire logic rd_valid,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic rsp_conn
);
  logic wr_ff;
  logic conn_ff;
  logic [5:0] len_ff;
  logic [5:0] rdc_ff;
  logic [5:0] wbc_ff;

  // Capture each accepted request and count the bytes moved for it
  always_ff @(posedge clk) begin
    if (req_valid && req_ready) begin
      wr_ff <= req_write;
      conn_ff <= req_conn;
      len_ff <= req_len;
      rdc_ff <= 6'h00;
      wbc_ff <= 6'h00;
    end else begin
      rdc_ff <= rdc_ff + {5'h00, rd_valid};
      wbc_ff <= wbc_ff + {5'h00, wb_valid & wb_ready};
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  property p_len_range;
    req_valid |-> req_len != 6'h00 && req_len <= 6'h30;
  endproperty
  a_len_range: assert property (p_len_range) else $error("Link length out of range");
  property p_even_term;
    req_valid && req_slot != 8'h00 && req_slot <= 8'h40 |-> !req_len[0];
  endproperty
  a_even_term: assert property (p_even_term) else $error("Odd terminal length");
  property p_req_hold;
    req_valid && !req_ready |=> req_valid && $stable(req_slot) && $stable(req_len);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("Request changed while waiting");
  property p_wb_hold;
    wb_valid && !wb_ready |=> wb_valid && $stable(wb_data);
  endproperty
  a_wb_hold: assert property (p_wb_hold) else $error("Write byte changed while waiting");
  property p_one_open;
    req_valid && req_ready |=> !req_ready;
  endproperty
  a_one_open: assert property (p_one_open) else $error("Ready stayed up after take");
  property p_ready_hold;
    $past(rstn) && !req_ready && !rsp_valid |=> !req_ready;
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("Ready rose without answer");
  property p_rsp_bound;
    req_valid && req_ready |=> !rsp_valid ##[1:999] rsp_valid;
  endproperty
  a_rsp_bound: assert property (p_rsp_bound) else $error("Answer late or early");
  property p_conn_echo;
    rsp_valid |-> rsp_conn == conn_ff;
  endproperty
  a_conn_echo: assert property (p_conn_echo) else $error("Connection not echoed");
  property p_rd_count;
    rsp_valid && !rsp_err && !wr_ff |-> rdc_ff == len_ff;
  endproperty
  a_rd_count: assert property (p_rd_count) else $error("Read byte count wrong");
  property p_err_nodata;
    rsp_valid && rsp_err && !wr_ff |-> rdc_ff == 6'h00;
  endproperty
  a_err_nodata: assert property (p_err_nodata) else $error("Data sent with error");
  property p_wb_count;
    rsp_valid && wr_ff |-> wbc_ff == len_ff;
  endproperty
  a_wb_count: assert property (p_wb_count) else $error("Write byte count wrong");
endmodule

// [tb/asid_tb.sv]
// Self-checking bench joining the master end to the decoder end
`timescale 1ns/10ps
module asid_tb;
  logic clk, rstn, cmd_valid, cmd_ready_ff, cmd_write, cmd_conn, ub_we;
  logic [7:0] cmd_slot, cmd_index, ub_data, usr_rd_data_ff, treg_slot_ff, treg_num_ff;
  logic [5:0] cmd_len, ub_addr;
  logic usr_rd_valid_ff, done_ff, done_err_ff, done_local_ff, treg_req_ff, treg_we_ff;
  logic cyc_meas_ff, cyc_load_ff, wprot_ff, factory_ff, tbus_rst_ff;
  logic treg_ack = 1'b0;
  logic [15:0] treg_rdat = 16'h0000;
  logic [15:0] treg_wdat_ff;
  logic [63:0] cyc_times, cyc_val_ff, cyc_got;
  logic [10:0] img_addr;
  logic [7:0] img_rdat_ff;
  logic [7:0] wbuf [0:47];
  logic [7:0] mdl [0:1535];
  logic [7:0] exp_rd[$];
  logic [1:0] exp_done[$];
  logic [23:0] tw_q[$];
  int n_fail = 0;
  int n_checks = 0;
  int n_done = 0;
  int n_fact = 0;
  int n_tbr = 0;

  asid_if lnk();
  asid_dev i_asid_dev(.clk(clk), .rstn(rstn), .lnk(lnk.dev), .term_cnt(7'h04),
    .treg_req_ff(treg_req_ff), .treg_we_ff(treg_we_ff), .treg_slot_ff(treg_slot_ff),
    .treg_num_ff(treg_num_ff), .treg_wdat_ff(treg_wdat_ff), .treg_ack(treg_ack),
    .treg_rdat(treg_rdat), .cyc_times(cyc_times), .cyc_meas_ff(cyc_meas_ff),
    .cyc_load_ff(cyc_load_ff), .cyc_val_ff(cyc_val_ff), .wprot_ff(wprot_ff),
    .factory_ff(factory_ff), .tbus_rst_ff(tbus_rst_ff), .img_addr(img_addr),
    .img_rdat_ff(img_rdat_ff));
  asid_mst i_asid_mst(.clk(clk), .rstn(rstn), .lnk(lnk.mst), .cmd_valid(cmd_valid),
    .cmd_ready_ff(cmd_ready_ff), .cmd_write(cmd_write), .cmd_conn(cmd_conn),
    .cmd_slot(cmd_slot), .cmd_index(cmd_index), .cmd_len(cmd_len), .ub_we(ub_we),
    .ub_addr(ub_addr), .ub_data(ub_data), .usr_rd_valid_ff(usr_rd_valid_ff),
    .usr_rd_data_ff(usr_rd_data_ff), .done_ff(done_ff), .done_err_ff(done_err_ff),
    .done_local_ff(done_local_ff));
  asid_properties i_asid_properties(.clk(clk), .rstn(rstn), .req_valid(lnk.req_valid),
    .req_ready(lnk.req_ready), .req_write(lnk.req_write), .req_conn(lnk.req_conn),
    .req_slot(lnk.req_slot), .req_len(lnk.req_len), .wb_valid(lnk.wb_valid),
    .wb_ready(lnk.wb_ready), .wb_data(lnk.wb_data), .rd_valid(lnk.rd_valid),
    .rsp_valid(lnk.rsp_valid), .rsp_err(lnk.rsp_err), .rsp_conn(lnk.rsp_conn));

  // Clock of 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Terminal stand-in: answers each register request one cycle later
  always @(negedge clk) begin
    treg_ack <= (treg_req_ff === 1'b1);
    treg_rdat <= (treg_req_ff === 1'b1) ? {treg_slot_ff, treg_num_ff} : ~treg_rdat;
    if (treg_req_ff === 1'b1 && treg_we_ff === 1'b1) tw_q.push_back({treg_num_ff, treg_wdat_ff});
  end

  task automatic chk(input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  // Output watcher: read bytes and completions against the oldest notes
  always @(posedge clk) begin
    if (usr_rd_valid_ff === 1'b1)
      chk(exp_rd.size() > 0 ? 64'(exp_rd.pop_front()) : 64'h100, 64'(usr_rd_data_ff));
    if (done_ff === 1'b1) begin
      n_done++;
      chk(64'(exp_done.pop_front()), {62'h0, done_local_ff, done_err_ff});
    end
    if (factory_ff === 1'b1) n_fact++;
    if (tbus_rst_ff === 1'b1) n_tbr++;
    if (cyc_load_ff === 1'b1) cyc_got = cyc_val_ff;
  end

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic pw(input logic [15:0] v);
    exp_rd.push_back(v[15:8]);
    exp_rd.push_back(v[7:0]);
  endtask

  // One master command: load write bytes, hand over, await completion
  task automatic cmd(input logic wr, input logic [7:0] sl, input logic [7:0] ix,
                     input logic [5:0] ln, input logic [1:0] ex);
    int k;
    int w;
    for (k = 0; wr && k < int'(ln); k++) begin
      @(negedge clk);
      ub_we = 1'b1;
      ub_addr = 6'(k);
      ub_data = wbuf[k];
    end
    @(negedge clk);
    ub_we = 1'b0;
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_conn = 1'($urandom);
    cmd_slot = sl;
    cmd_index = ix;
    cmd_len = ln;
    exp_done.push_back(ex);
    k = n_done;
    do @(posedge clk); while (cmd_ready_ff !== 1'b1);
    @(negedge clk);
    cmd_valid = 1'b0;
    for (w = 0; n_done == k && w < 3000; w++) @(negedge clk);
    chk(64'(k + 1), 64'(n_done));
  endtask

  // Watchdog
  initial begin
    #3_000_000;
    n_fail++;
    end_sim;
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] bad [13];
    int a, w, n, o, b, k;
    bad = '{32'h0200_0002, 32'h0200_8B01, 32'h0200_8A21, 32'h0205_0002, 32'h0241_0002,
            32'h02FE_0002, 32'h03FB_0002, 32'h0300_E303, 32'h0600_2100, 32'h0601_0003,
            32'h0300_2003, 32'h0700_E002, 32'h0600_8031};
    rstn = 1'b0;
    {cmd_valid, cmd_write, cmd_conn, ub_we, cmd_slot, cmd_index, cmd_len} = '0;
    {ub_addr, ub_data, img_addr} = '0;
    cyc_times = '0;
    void'($urandom(32'hab98));
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    pw(16'h0018);
    pw(16'h0019);
    cmd(1'b0, 8'h00, 8'h02, 6'd4, 2'b00);
    for (k = 0; k < 17; k++) pw(16'(48 + k));
    cmd(1'b0, 8'h00, 8'h03, 6'd34, 2'b00);
    cmd(1'b0, 8'h00, 8'h03, 6'd36, 2'b01);
    pw(16'h04FE);
    pw(16'h04FF);
    cmd(1'b0, 8'h04, 8'hFE, 6'd4, 2'b00);
    cmd(1'b0, 8'h04, 8'hFE, 6'd6, 2'b01);
    for (k = 0; k < 8; k++) wbuf[k] = 8'($urandom);
    cmd(1'b1, 8'h01, 8'h07, 6'd4, 2'b00);
    chk({8'h07, wbuf[0], wbuf[1]}, 64'(tw_q.pop_front()));
    chk({8'h08, wbuf[2], wbuf[3]}, 64'(tw_q.pop_front()));
    $display("Test terminal done");
    cyc_times = {$urandom, $urandom};
    for (k = 3; k >= 0; k--) pw(cyc_times[16 * k +: 16]);
    cmd(1'b0, 8'h00, 8'h21, 6'd8, 2'b00);
    cmd(1'b1, 8'h00, 8'h21, 6'd8, 2'b00);
    chk({wbuf[0], wbuf[1], wbuf[2], wbuf[3], wbuf[4], wbuf[5], wbuf[6], wbuf[7]}, cyc_got);
    {wbuf[0], wbuf[1]} = 16'h0001;
    cmd(1'b1, 8'h00, 8'h20, 6'd2, 2'b00);
    chk(64'h1, 64'(cyc_meas_ff));
    wbuf[1] = 8'h00;
    cmd(1'b1, 8'h00, 8'h20, 6'd2, 2'b00);
    chk(64'h0, 64'(cyc_meas_ff));
    $display("Test cycle done");
    for (k = 1; k < 4; k++) begin
      wbuf[0] = 8'(k);
      cmd(1'b1, 8'h00, 8'h10, 6'd1, {1'b0, k == 3});
    end
    chk(64'h1, 64'(n_fact));
    chk(64'h1, 64'(n_tbr));
    {wbuf[0], wbuf[1], wbuf[2]} = 24'h00_005A;
    mdl[0] = 8'h5A;
    cmd(1'b1, 8'h00, 8'hE0, 6'd3, 2'b00);
    wbuf[0] = 8'h00;
    cmd(1'b1, 8'h00, 8'h10, 6'd1, 2'b00);
    chk(64'h1, 64'(wprot_ff));
    wbuf[2] = 8'hA5;
    cmd(1'b1, 8'h00, 8'hE0, 6'd3, 2'b01);
    exp_rd.push_back(mdl[0]);
    cmd(1'b0, 8'h00, 8'h80, 6'd1, 2'b00);
    {wbuf[0], wbuf[1], wbuf[2]} = 24'h00_FEAF;
    cmd(1'b1, 8'h00, 8'h10, 6'd3, 2'b00);
    chk(64'h0, 64'(wprot_ff));
    $display("Test functions done");
    for (a = 0; a < 3; a++) begin
      w = $urandom_range(10);
      n = (w == 10) ? 32 : $urandom_range(46, 1);
      o = w * 48;
      {wbuf[0], wbuf[1]} = 16'(o);
      for (k = 0; k < n; k++) begin
        wbuf[k + 2] = 8'($urandom);
        mdl[a * 512 + o + k] = wbuf[k + 2];
      end
      cmd(1'b1, 8'h00, 8'(224 + a), 6'(n + 2), 2'b00);
      b = o * 8 + $urandom_range(7);
      {wbuf[0], wbuf[1]} = 16'(b);
      wbuf[2] = {7'h00, ~mdl[a * 512 + o][b % 8]};
      mdl[a * 512 + o][b % 8] = wbuf[2][0];
      cmd(1'b1, 8'h00, 8'(227 + a), 6'd3, 2'b00);
      for (k = 0; k < n; k++) exp_rd.push_back(mdl[a * 512 + o + k]);
      cmd(1'b0, 8'h00, 8'(128 + 16 * a + w), 6'(n), 2'b00);
      for (k = 0; k < n; k++) exp_rd.push_back(mdl[a * 512 + o + k]);
      cmd(1'b0, 8'(251 + a), 8'(w * 24), 6'(n), 2'b00);
      img_addr = 11'(a * 512 + o);
      repeat (2) @(negedge clk);
      chk(64'(mdl[a * 512 + o]), 64'(img_rdat_ff));
    end
    $display("Test images done");
    {wbuf[0], wbuf[1], wbuf[2]} = 24'h00_0002;
    for (k = 0; k < 13; k++)
      cmd(bad[k][24], bad[k][23:16], bad[k][15:8], bad[k][5:0], bad[k][26:25]);
    chk(64'h0, 64'(exp_rd.size()));
    $display("Test refusals done");
    end_sim;
  end
endmodule
